// File: hw/imc_pkg.sv
// shared constants and types of the i2c master collision sequencer
package imc_pkg;
    // register port and rate counter widths
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned RATE_W = 7;
    // register offsets (word index on the plain register port)
    localparam logic [3:0] OFS_FLAGS_A = 4'h0;
    localparam logic [3:0] OFS_ENABLES_A = 4'h1;
    localparam logic [3:0] OFS_PRIORITY_A = 4'h2;
    localparam logic [3:0] OFS_FLAGS_B = 4'h3;
    localparam logic [3:0] OFS_ENABLES_B = 4'h4;
    localparam logic [3:0] OFS_PRIORITY_B = 4'h5;
    localparam logic [3:0] OFS_DATA_BUF = 4'h6;
    localparam logic [3:0] OFS_RELOAD = 4'h7;
    localparam logic [3:0] OFS_CTL_ONE = 4'h8;
    localparam logic [3:0] OFS_CTL_TWO = 4'h9;
    localparam logic [3:0] OFS_STATUS = 4'ha;
    // field positions
    localparam int unsigned SERIAL_IRQ_BIT = 3;
    localparam int unsigned COLL_IRQ_BIT = 3;
    localparam int unsigned CTL1_EN_BIT = 5;
    localparam int unsigned CTL1_MODE_LSB = 0;
    localparam int unsigned CTL2_START_BIT = 0;
    localparam int unsigned CTL2_RSTART_BIT = 1;
    localparam int unsigned CTL2_STOP_BIT = 2;
    localparam int unsigned CTL2_RECV_BIT = 3;
    localparam int unsigned CTL2_ACK_BIT = 4;
    localparam int unsigned CTL2_ACKDT_BIT = 5;
    localparam int unsigned MASK_LSB = 1;
    localparam int unsigned MASK_W = 5;
    localparam int unsigned STAT_STOP_BIT = 4;
    localparam int unsigned STAT_START_BIT = 3;
    // mode field value that selects master operation
    localparam logic [3:0] MODE_MASTER = 4'h8;
    // request bits cleared by a collision abort
    localparam logic [7:0] CTL2_REQ_MASK = 8'h17;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // sequencer states
    typedef enum logic [4:0] {
        ST_IDLE, ST_CHK, ST_CNT1, ST_CNT2,
        RS_SDA_REL, RS_CNT1, RS_SCL_WAIT, RS_HOLD1, RS_HOLD2,
        SP_SDA_LOW, SP_CNT1, SP_SCL_WAIT, SP_CNT2, SP_CNT3,
        AK_CNT1, AK_SCL_WAIT, AK_CNT2
    } imc_state_e_t;

    // register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } imc_bus_req_t;

    // one bit per bus line
    typedef struct packed {
        logic sda;
        logic scl;
    } imc_lines_t;

    // complete state of the sequencer
    typedef struct packed {
        imc_state_e_t state;
        logic [RATE_W-1:0] cnt;
        logic sda_drv;
        logic scl_drv;
        logic [2:0] sda_s;
        logic [2:0] scl_s;
        logic sda_lvl;
        logic scl_lvl;
        logic [DATA_W-1:0] flags_a;
        logic [DATA_W-1:0] en_a;
        logic [DATA_W-1:0] pri_a;
        logic [DATA_W-1:0] flags_b;
        logic [DATA_W-1:0] en_b;
        logic [DATA_W-1:0] pri_b;
        logic [DATA_W-1:0] dbuf;
        logic [DATA_W-1:0] reload;
        logic [DATA_W-1:0] ctl1;
        logic [DATA_W-1:0] ctl2;
        logic [MASK_W-1:0] mask;
        logic stop_seen;
        logic start_seen;
        logic [DATA_W-1:0] rdata;
        logic irq;
    } imc_state_t;
endpackage

// File: hw/imc_master_seq.sv
// i2c master start / repeated start / stop / ack sequencer with collision detection
// Behaviour
// - repeated start: sda low at scl rise collides
// - repeated start: scl falls before sda driven collides
// - released sda high loads rate counter, counts down
// - then release scl; high scl, low sda collides
// - high sda reloads counter; early sda fall tolerated
// - scl falling before expiry, sda undriven, collides
// - scl high at expiry: drive sda, recount
// - final expiry drives scl low, sequence done
// - stop: released sda low after expiry collides
// - stop: scl low before sda high collides
// - stop starts sda low; scl released after
// - stop: scl high loads counter, then samples sda
// - slave mode: control two bits 5:1 are mask
// - collision sets flag, returns to idle
// - collision releases lines, clears sequence request bit
`timescale 1ns/10ps
`default_nettype none
module imc_master_seq (
    // clock and synchronous active-low reset
    input wire logic core_clk,
    input wire logic nrst,
    // register port
    input wire imc_pkg::imc_bus_req_t bus_req,
    output logic [imc_pkg::DATA_W-1:0] rdata,
    // interrupt
    output logic irq,
    // open-drain bus lines: input level, output level, output enable
    input wire imc_pkg::imc_lines_t line_in,
    output imc_pkg::imc_lines_t line_out,
    output imc_pkg::imc_lines_t line_oe
);
    imc_pkg::imc_state_t s; // registered state
    imc_pkg::imc_state_t next_s; // next state
    logic coll; // collision seen this cycle
    logic done; // sequence completed this cycle
    logic expired; // rate counter at zero
    logic master; // master mode selected
    logic ctl2_wr; // write hit on control two

    // read mux, shared by the register read path
    function automatic logic [imc_pkg::DATA_W-1:0] reg_read(
        input imc_pkg::imc_state_t st,
        input logic [imc_pkg::ADDR_W-1:0] a,
        input logic is_master
    );
        logic [imc_pkg::DATA_W-1:0] v;
        v = imc_pkg::RESET_BYTE;
        case (a)
            imc_pkg::OFS_FLAGS_A: v = st.flags_a;
            imc_pkg::OFS_ENABLES_A: v = st.en_a;
            imc_pkg::OFS_PRIORITY_A: v = st.pri_a;
            imc_pkg::OFS_FLAGS_B: v = st.flags_b;
            imc_pkg::OFS_ENABLES_B: v = st.en_b;
            imc_pkg::OFS_PRIORITY_B: v = st.pri_b;
            imc_pkg::OFS_DATA_BUF: v = st.dbuf;
            imc_pkg::OFS_RELOAD: v = st.reload;
            imc_pkg::OFS_CTL_ONE: v = st.ctl1;
            imc_pkg::OFS_CTL_TWO: begin
                v = st.ctl2;
                // slave view shows the address mask in bits 5:1
                if (!is_master) begin
                    v[imc_pkg::MASK_LSB +: imc_pkg::MASK_W] = st.mask;
                end
            end
            imc_pkg::OFS_STATUS: begin
                v[imc_pkg::STAT_STOP_BIT] = st.stop_seen;
                v[imc_pkg::STAT_START_BIT] = st.start_seen;
            end
            default: v = imc_pkg::RESET_BYTE; // unmapped reads as zero
        endcase
        return v;
    endfunction

    // outputs other than the tied-low line_out come straight from the state flip-flops
    assign rdata = s.rdata;
    assign irq = s.irq;
    assign line_out.sda = 1'b0; // open drain: only ever pulls low
    assign line_out.scl = 1'b0;
    assign line_oe.sda = s.sda_drv;
    assign line_oe.scl = s.scl_drv;

    assign expired = (s.cnt == '0);
    assign master = (s.ctl1[imc_pkg::CTL1_MODE_LSB +: 4] == imc_pkg::MODE_MASTER);
    assign ctl2_wr = bus_req.wr && (bus_req.addr == imc_pkg::OFS_CTL_TWO);

    // next-state logic: synchronisers, sequencer, registers
    always_comb begin
        next_s = s;
        coll = 1'b0;
        done = 1'b0;
        // three-stage synchronisers; a level counts once stages two and three agree
        next_s.sda_s = {s.sda_s[1:0], line_in.sda};
        next_s.scl_s = {s.scl_s[1:0], line_in.scl};
        if (s.sda_s[1] == s.sda_s[2]) begin
            next_s.sda_lvl = s.sda_s[2];
        end
        if (s.scl_s[1] == s.scl_s[2]) begin
            next_s.scl_lvl = s.scl_s[2];
        end
        // rate counter runs down and rests at zero
        if (!expired) begin
            next_s.cnt = s.cnt - 1'b1;
        end

        // sequencer
        case (s.state)
            imc_pkg::ST_IDLE: begin
                // one request at a time, start first
                if (master && s.ctl1[imc_pkg::CTL1_EN_BIT]) begin
                    if (s.ctl2[imc_pkg::CTL2_START_BIT]) begin
                        next_s.sda_drv = 1'b0;
                        next_s.scl_drv = 1'b0;
                        next_s.state = imc_pkg::ST_CHK;
                    end else if (s.ctl2[imc_pkg::CTL2_RSTART_BIT]) begin
                        // scl still held low from the last byte; free sda first
                        next_s.sda_drv = 1'b0;
                        next_s.scl_drv = 1'b1;
                        next_s.state = imc_pkg::RS_SDA_REL;
                    end else if (s.ctl2[imc_pkg::CTL2_STOP_BIT]) begin
                        next_s.sda_drv = 1'b1;
                        next_s.scl_drv = 1'b1;
                        next_s.state = imc_pkg::SP_SDA_LOW;
                    end else if (s.ctl2[imc_pkg::CTL2_ACK_BIT]) begin
                        next_s.scl_drv = 1'b1;
                        next_s.sda_drv = !s.ctl2[imc_pkg::CTL2_ACKDT_BIT];
                        next_s.cnt = s.reload[imc_pkg::RATE_W-1:0];
                        next_s.state = imc_pkg::AK_CNT1;
                    end
                end
            end
            // start: both lines must be free, then sda low, then scl low
            imc_pkg::ST_CHK: begin
                if (!s.sda_lvl || !s.scl_lvl) begin
                    coll = 1'b1;
                end else begin
                    next_s.cnt = s.reload[imc_pkg::RATE_W-1:0];
                    next_s.state = imc_pkg::ST_CNT1;
                end
            end
            imc_pkg::ST_CNT1: begin
                if (!s.scl_lvl) begin
                    coll = 1'b1;
                end else if (!s.sda_lvl || expired) begin
                    // a foreign sda fall only makes us assert early
                    next_s.sda_drv = 1'b1;
                    next_s.cnt = s.reload[imc_pkg::RATE_W-1:0];
                    next_s.state = imc_pkg::ST_CNT2;
                end
            end
            imc_pkg::ST_CNT2: begin
                if (expired) begin
                    next_s.scl_drv = 1'b1;
                    next_s.start_seen = 1'b1;
                    next_s.ctl2[imc_pkg::CTL2_START_BIT] = 1'b0;
                    done = 1'b1;
                    next_s.state = imc_pkg::ST_IDLE;
                end
            end
            // repeated start
            imc_pkg::RS_SDA_REL: begin
                if (s.sda_lvl) begin
                    next_s.cnt = s.reload[imc_pkg::RATE_W-1:0];
                    next_s.state = imc_pkg::RS_CNT1;
                end
            end
            imc_pkg::RS_CNT1: begin
                if (expired) begin
                    next_s.scl_drv = 1'b0;
                    next_s.state = imc_pkg::RS_SCL_WAIT;
                end
            end
            imc_pkg::RS_SCL_WAIT: begin
                // scl rising edge: sda is sampled here
                if (s.scl_lvl) begin
                    if (!s.sda_lvl) begin
                        coll = 1'b1;
                    end else begin
                        next_s.cnt = s.reload[imc_pkg::RATE_W-1:0];
                        next_s.state = imc_pkg::RS_HOLD1;
                    end
                end
            end
            imc_pkg::RS_HOLD1: begin
                // sda not yet driven by us; a falling scl means a rival sends a one
                if (!s.scl_lvl) begin
                    coll = 1'b1;
                end else if (expired) begin
                    // an sda fall before expiry is a rival start, not a collision
                    next_s.sda_drv = 1'b1;
                    next_s.cnt = s.reload[imc_pkg::RATE_W-1:0];
                    next_s.state = imc_pkg::RS_HOLD2;
                end
            end
            imc_pkg::RS_HOLD2: begin
                // scl level is deliberately ignored here
                if (expired) begin
                    next_s.scl_drv = 1'b1;
                    next_s.start_seen = 1'b1;
                    next_s.ctl2[imc_pkg::CTL2_RSTART_BIT] = 1'b0;
                    done = 1'b1;
                    next_s.state = imc_pkg::ST_IDLE;
                end
            end
            // stop
            imc_pkg::SP_SDA_LOW: begin
                // scl stays held until our low sda is seen on the wire
                if (!s.sda_lvl) begin
                    next_s.cnt = s.reload[imc_pkg::RATE_W-1:0];
                    next_s.state = imc_pkg::SP_CNT1;
                end
            end
            imc_pkg::SP_CNT1: begin
                if (expired) begin
                    next_s.scl_drv = 1'b0;
                    next_s.state = imc_pkg::SP_SCL_WAIT;
                end
            end
            imc_pkg::SP_SCL_WAIT: begin
                // clock stretching: wait as long as scl is held low
                if (s.scl_lvl) begin
                    next_s.cnt = s.reload[imc_pkg::RATE_W-1:0];
                    next_s.state = imc_pkg::SP_CNT2;
                end
            end
            imc_pkg::SP_CNT2: begin
                if (!s.scl_lvl) begin
                    coll = 1'b1;
                end else if (expired) begin
                    next_s.sda_drv = 1'b0;
                    next_s.cnt = s.reload[imc_pkg::RATE_W-1:0];
                    next_s.state = imc_pkg::SP_CNT3;
                end
            end
            imc_pkg::SP_CNT3: begin
                if (!s.scl_lvl && !s.sda_lvl) begin
                    coll = 1'b1;
                end else if (expired) begin
                    if (!s.sda_lvl) begin
                        coll = 1'b1;
                    end else begin
                        next_s.stop_seen = 1'b1;
                        next_s.start_seen = 1'b0;
                        next_s.ctl2[imc_pkg::CTL2_STOP_BIT] = 1'b0;
                        done = 1'b1;
                        next_s.state = imc_pkg::ST_IDLE;
                    end
                end
            end
            // acknowledge
            imc_pkg::AK_CNT1: begin
                if (expired) begin
                    next_s.scl_drv = 1'b0;
                    next_s.state = imc_pkg::AK_SCL_WAIT;
                end
            end
            imc_pkg::AK_SCL_WAIT: begin
                if (s.scl_lvl) begin
                    next_s.cnt = s.reload[imc_pkg::RATE_W-1:0];
                    next_s.state = imc_pkg::AK_CNT2;
                end
            end
            imc_pkg::AK_CNT2: begin
                if (expired) begin
                    next_s.scl_drv = 1'b1;
                    next_s.sda_drv = 1'b0;
                    next_s.ctl2[imc_pkg::CTL2_ACK_BIT] = 1'b0;
                    done = 1'b1;
                    next_s.state = imc_pkg::ST_IDLE;
                end
            end
            default: next_s.state = imc_pkg::ST_IDLE;
        endcase

        // collision abort: lines free, requests dropped, back to idle
        if (coll) begin
            next_s.state = imc_pkg::ST_IDLE;
            next_s.sda_drv = 1'b0;
            next_s.scl_drv = 1'b0;
            next_s.ctl2 = s.ctl2 & ~imc_pkg::CTL2_REQ_MASK;
        end
        // disabling the port frees the lines, returns to idle and clears the status bits
        if (!s.ctl1[imc_pkg::CTL1_EN_BIT]) begin
            next_s.state = imc_pkg::ST_IDLE;
            next_s.sda_drv = 1'b0;
            next_s.scl_drv = 1'b0;
            next_s.stop_seen = 1'b0;
            next_s.start_seen = 1'b0;
        end

        // register writes; sticky flags clear by writing one
        if (bus_req.wr) begin
            case (bus_req.addr)
                imc_pkg::OFS_FLAGS_A: next_s.flags_a = s.flags_a & ~bus_req.wdata;
                imc_pkg::OFS_ENABLES_A: next_s.en_a = bus_req.wdata;
                imc_pkg::OFS_PRIORITY_A: next_s.pri_a = bus_req.wdata;
                imc_pkg::OFS_FLAGS_B: next_s.flags_b = s.flags_b & ~bus_req.wdata;
                imc_pkg::OFS_ENABLES_B: next_s.en_b = bus_req.wdata;
                imc_pkg::OFS_PRIORITY_B: next_s.pri_b = bus_req.wdata;
                imc_pkg::OFS_DATA_BUF: next_s.dbuf = bus_req.wdata;
                imc_pkg::OFS_RELOAD: next_s.reload = bus_req.wdata;
                imc_pkg::OFS_CTL_ONE: next_s.ctl1 = bus_req.wdata;
                default: next_s.flags_a = next_s.flags_a; // control two is written below; other offsets ignore writes
            endcase
        end
        if (ctl2_wr) begin
            if (master) begin
                next_s.ctl2 = bus_req.wdata;
            end else begin
                // slave mode: bits 5:1 land in the mask, not in the requests
                next_s.mask = bus_req.wdata[imc_pkg::MASK_LSB +: imc_pkg::MASK_W];
                next_s.ctl2[7:6] = bus_req.wdata[7:6];
                next_s.ctl2[imc_pkg::CTL2_START_BIT] = bus_req.wdata[imc_pkg::CTL2_START_BIT];
            end
        end
        // hardware sets after the software clear, so a same-cycle event survives
        if (coll) begin
            next_s.flags_b[imc_pkg::COLL_IRQ_BIT] = 1'b1;
        end
        if (done) begin
            next_s.flags_a[imc_pkg::SERIAL_IRQ_BIT] = 1'b1;
        end

        // read data valid in the cycle after the read strobe only
        next_s.rdata = imc_pkg::RESET_BYTE;
        if (bus_req.rd) begin
            next_s.rdata = reg_read(s, bus_req.addr, master);
        end
        // level interrupt from the updated flags and masks
        next_s.irq = |((next_s.flags_a & next_s.en_a) | (next_s.flags_b & next_s.en_b));
    end

    // state register; synchronous reset clears all control state
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            s <= '0;
            s.sda_s <= 3'h7;
            s.scl_s <= 3'h7;
            s.sda_lvl <= 1'b1;
            s.scl_lvl <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // checks
    chk_coll_sets_flag: assert property (@(posedge core_clk) disable iff (!nrst)
        coll |=> (s.flags_b[imc_pkg::COLL_IRQ_BIT] && s.state == imc_pkg::ST_IDLE))
        else $error("collision did not set flag or reach idle");
    chk_coll_frees_lines: assert property (@(posedge core_clk) disable iff (!nrst)
        coll |=> (!s.sda_drv && !s.scl_drv && (s.ctl2 & imc_pkg::CTL2_REQ_MASK) == '0))
        else $error("collision left a line driven or a request set");
    chk_rs_sda_rise: assert property (@(posedge core_clk) disable iff (!nrst)
        (s.state == imc_pkg::RS_SCL_WAIT && s.scl_lvl && !s.sda_lvl) |-> coll)
        else $error("low sda at scl rise not flagged");
    chk_rs_scl_fall: assert property (@(posedge core_clk) disable iff (!nrst)
        (s.state == imc_pkg::RS_HOLD1 && !s.scl_lvl && !s.sda_drv) |-> coll)
        else $error("early scl fall not flagged");
    chk_rs_load_count: assert property (@(posedge core_clk) disable iff (!nrst)
        (s.state == imc_pkg::RS_SDA_REL && s.sda_lvl && s.ctl1[imc_pkg::CTL1_EN_BIT])
        |=> (s.state == imc_pkg::RS_CNT1 && s.cnt == $past(s.reload[imc_pkg::RATE_W-1:0])))
        else $error("rate counter not loaded on released sda");
    chk_rs_sda_early: assert property (@(posedge core_clk) disable iff (!nrst)
        (s.state == imc_pkg::RS_HOLD1 && s.scl_lvl && !s.sda_lvl) |-> !coll)
        else $error("early sda fall wrongly flagged");
    chk_rs_drive_sda: assert property (@(posedge core_clk) disable iff (!nrst)
        (s.state == imc_pkg::RS_HOLD1 && expired && s.scl_lvl && s.ctl1[imc_pkg::CTL1_EN_BIT])
        |=> (s.sda_drv && s.state == imc_pkg::RS_HOLD2))
        else $error("sda not driven at expiry");
    chk_rs_scl_end: assert property (@(posedge core_clk) disable iff (!nrst)
        (s.state == imc_pkg::RS_HOLD2 && expired && s.ctl1[imc_pkg::CTL1_EN_BIT])
        |=> (s.scl_drv && s.state == imc_pkg::ST_IDLE && s.flags_a[imc_pkg::SERIAL_IRQ_BIT]))
        else $error("repeated start did not end with scl low");
    chk_sp_sda_low: assert property (@(posedge core_clk) disable iff (!nrst)
        (s.state == imc_pkg::SP_CNT3 && expired && !s.sda_lvl) |-> coll)
        else $error("low sda after stop count not flagged");
    chk_sp_scl_low: assert property (@(posedge core_clk) disable iff (!nrst)
        (s.state == imc_pkg::SP_CNT2 && !s.scl_lvl) |-> coll)
        else $error("low scl during stop not flagged");
    chk_sp_hold_scl: assert property (@(posedge core_clk) disable iff (!nrst)
        (s.state == imc_pkg::SP_SDA_LOW && s.sda_lvl && s.ctl1[imc_pkg::CTL1_EN_BIT])
        |=> (s.state == imc_pkg::SP_SDA_LOW && s.scl_drv && s.sda_drv))
        else $error("scl released before sda seen low");
    chk_sp_load_count: assert property (@(posedge core_clk) disable iff (!nrst)
        (s.state == imc_pkg::SP_SCL_WAIT && s.scl_lvl && s.ctl1[imc_pkg::CTL1_EN_BIT])
        |=> (s.state == imc_pkg::SP_CNT2 && s.cnt == $past(s.reload[imc_pkg::RATE_W-1:0])))
        else $error("stop count not loaded on scl high");
    chk_slave_mask: assert property (@(posedge core_clk) disable iff (!nrst)
        (ctl2_wr && !master) |=> (s.mask == $past(bus_req.wdata[imc_pkg::MASK_LSB +: imc_pkg::MASK_W])
        && s.ctl2[4:1] == $past(s.ctl2[4:1])))
        else $error("slave write changed sequence bits");
endmodule
`default_nettype wire

// File: testbench/imc_bus_peer.sv
// other masters and slaves on the shared open-drain bus
`timescale 1ns/10ps
`default_nettype none
module imc_bus_peer (
    // link clock and pull requests from the bench
    input wire logic lclk,
    input wire logic hold_sda,
    input wire logic hold_scl,
    // device drive and resolved wire levels
    input wire imc_pkg::imc_lines_t dev_oe,
    output var imc_pkg::imc_lines_t line
);
    logic p_sda = 1'b0; // peer pulls sda low
    logic p_scl = 1'b0; // peer pulls scl low
    // the peer moves on its own clock, so its edges land at any core phase
    always @(posedge lclk) begin
        p_sda <= hold_sda;
        p_scl <= hold_scl;
    end
    // wired-and with pull-ups: a released line reads high
    assign line.sda = ~(dev_oe.sda | p_sda);
    assign line.scl = ~(dev_oe.scl | p_scl);
endmodule
`default_nettype wire

// File: testbench/i2c_master_collision_rstart_stop_tb_top.sv
// bench for the collision-aware start, repeated start and stop sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module i2c_master_collision_rstart_stop_tb_top;
    logic core_clk = 1'b0; // 250 mhz core clock
    logic lclk = 1'b0; // peer link clock
    logic nrst = 1'b0;
    imc_pkg::imc_bus_req_t bus_req = '0;
    logic [7:0] rdata;
    logic irq;
    imc_pkg::imc_lines_t line_in;
    imc_pkg::imc_lines_t line_oe;
    imc_pkg::imc_lines_t line_out; // open-drain data levels, always low
    logic hold_sda = 1'b0;
    logic hold_scl = 1'b0;
    int error_cnt = 0;
    int n_checks = 0;
    logic [7:0] d; // last read value
    always #2 core_clk = ~core_clk;
    always #62.5 lclk = ~lclk;
    imc_master_seq dut (.core_clk(core_clk), .nrst(nrst), .bus_req(bus_req), .rdata(rdata),
        .irq(irq), .line_in(line_in), .line_out(line_out), .line_oe(line_oe));
    imc_bus_peer peer (.lclk(lclk), .hold_sda(hold_sda), .hold_scl(hold_scl),
        .dev_oe(line_oe), .line(line_in));
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        #1 d = rdata;
    endtask
    // issue a request, optionally pull a line after scl release, wait for the bit to drop
    task automatic go(input logic [7:0] req, input logic ps, input logic pc,
        input logic fall, input int dl);
        int i;
        wr(imc_pkg::OFS_CTL_TWO, req);
        if (fall) begin
            for (i = 0; i < 600 && line_oe.scl !== 1'b1; i++) @(posedge core_clk);
            if (i == 600) begin
                error_cnt++;
                $display("mismatch scl_hold exp 1 got %h", line_oe.scl);
                results();
            end
            for (i = 0; i < 600 && line_oe.scl !== 1'b0; i++) @(posedge core_clk);
            if (i == 600) begin
                error_cnt++;
                $display("mismatch scl_release exp 0 got %h", line_oe.scl);
                results();
            end
        end
        repeat (dl) @(posedge core_clk);
        hold_sda <= ps;
        hold_scl <= pc;
        for (i = 0; i < 400; i++) begin
            rd(imc_pkg::OFS_CTL_TWO);
            if ((d & req) === 8'h00) break;
        end
        if (i == 400) begin
            error_cnt++;
            $display("mismatch request_clear exp 00 got %h", d);
            results();
        end
        hold_sda <= 1'b0;
        hold_scl <= 1'b0;
        repeat (40) @(posedge core_clk);
    endtask
    // collision outcome: flag, interrupt, lines released, then clear
    task automatic coll(input string nm);
        rd(imc_pkg::OFS_FLAGS_B);
        `CHK(nm, 8'h08, d & 8'h08)
        `CHK("irq_set", 1'b1, irq)
        `CHK("oe_released", 2'b00, line_oe)
        wr(imc_pkg::OFS_FLAGS_B, 8'h08);
        repeat (2) @(posedge core_clk);
        #1 `CHK("irq_clear", 1'b0, irq)
        $display("test %s done", nm);
    endtask
    task automatic t_rstart_ok();
        go(8'h02, 1'b0, 1'b0, 1'b0, 0);
        rd(imc_pkg::OFS_FLAGS_A);
        `CHK("rs_done", 8'h08, d & 8'h08)
        `CHK("rs_sda_drive", 1'b1, line_oe.sda)
        `CHK("rs_scl_drive", 1'b1, line_oe.scl)
        wr(imc_pkg::OFS_FLAGS_A, 8'h08);
        $display("test rstart_ok done");
    endtask
    task automatic t_stop_ok();
        go(8'h04, 1'b0, 1'b0, 1'b0, 0);
        rd(imc_pkg::OFS_STATUS);
        `CHK("stop_seen", 8'h10, d & 8'h10)
        `CHK("stop_oe", 2'b00, line_oe)
        $display("test stop_ok done");
    endtask
    // rival pulls sda during the repeated start hold: tolerated, sequence completes
    task automatic t_rstart_sda_early();
        go(8'h02, 1'b1, 1'b0, 1'b1, 10);
        rd(imc_pkg::OFS_FLAGS_B);
        `CHK("rs_early_no_coll", 8'h00, d & 8'h08)
        rd(imc_pkg::OFS_FLAGS_A);
        `CHK("rs_early_done", 8'h08, d & 8'h08)
        wr(imc_pkg::OFS_FLAGS_A, 8'h08);
        $display("test rstart_sda_early done");
    endtask
    // plain start on a free bus, then an acknowledge with ack data zero
    task automatic t_start_ack();
        go(8'h01, 1'b0, 1'b0, 1'b0, 0);
        rd(imc_pkg::OFS_STATUS);
        `CHK("start_seen", 8'h08, d & 8'h08)
        `CHK("start_oe", 2'b11, line_oe)
        go(8'h10, 1'b0, 1'b0, 1'b0, 0);
        `CHK("ack_oe", 2'b01, line_oe)
        $display("test start_ack done");
    endtask
    task automatic t_mask();
        wr(imc_pkg::OFS_CTL_ONE, 8'h26);
        wr(imc_pkg::OFS_CTL_TWO, 8'h3e);
        rd(imc_pkg::OFS_CTL_TWO);
        `CHK("slave_mask", 8'h3e, d & 8'h3e)
        wr(imc_pkg::OFS_CTL_ONE, 8'h28);
        rd(imc_pkg::OFS_CTL_TWO);
        `CHK("mask_no_request", 8'h00, d & 8'h3e)
        $display("test mask done");
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        nrst <= 1'b1;
        rd(4'hb);
        `CHK("unmapped", 8'h00, d)
        `CHK("reset_oe", 2'b00, line_oe)
        `CHK("line_out", 2'b00, line_out)
        wr(imc_pkg::OFS_CTL_ONE, 8'h28);
        wr(imc_pkg::OFS_RELOAD, 8'h7f);
        wr(imc_pkg::OFS_ENABLES_B, 8'h08);
        t_rstart_ok();
        t_rstart_sda_early();
        go(8'h02, 1'b1, 1'b0, 1'b0, 40);
        coll("rs_sda_low");
        go(8'h02, 1'b0, 1'b1, 1'b1, 10);
        coll("rs_scl_fall");
        t_stop_ok();
        t_start_ack();
        go(8'h04, 1'b1, 1'b0, 1'b1, 10);
        coll("stop_sda_low");
        go(8'h04, 1'b0, 1'b1, 1'b1, 10);
        coll("stop_scl_low");
        t_mask();
        results();
    end
endmodule
`default_nettype wire
